// [verilog/ppr_regs.vh]
`ifndef PPR_REGS_VH
`define PPR_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define PPR_ADDR_W        8
`define PPR_OFS_MODE      8'h00
`define PPR_OFS_SRC       8'h04
`define PPR_OFS_SP_PCT    8'h08
`define PPR_OFS_FB_GAIN   8'h0C
`define PPR_OFS_KP        8'h10
`define PPR_OFS_TI        8'h14
`define PPR_OFS_TD        8'h18
`define PPR_OFS_BIAS      8'h1C
`define PPR_OFS_FILT      8'h20
`define PPR_OFS_ILIM      8'h24
`define PPR_OFS_OLIM      8'h28
`define PPR_OFS_OGAIN     8'h2C
`define PPR_OFS_REV       8'h30
`define PPR_OFS_RAMP      8'h34
`define PPR_OFS_STATUS    8'h38
`define PPR_OFS_OUT       8'h3C

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PPR_RST_MODE      4'h0
`define PPR_RST_SP_SRC    3'h1
`define PPR_RST_FB_SRC    3'h2
`define PPR_RST_GAIN      16'h0100
`define PPR_RST_ZERO      16'h0000
`define PPR_RST_LIM       16'h4000
`define PPR_RST_FILT      4'h0

// ------------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------------
`define PPR_MODE_EN       0
`define PPR_MODE_POL      1
`define PPR_MODE_DFB      2
`define PPR_MODE_ADD      3
`define PPR_SRC_SP_LSB    0
`define PPR_SRC_FB_LSB    8
`define PPR_SRC_KEYPAD    3'h0
`define PPR_SRC_AI1       3'h1
`define PPR_SRC_AI2       3'h2
`define PPR_SRC_STORED    3'h4
`define PPR_SRC_DIFF      3'h4
`define PPR_ST_ALARM      0
`define PPR_ST_REV        1
`define PPR_ST_RUN        2
`define PPR_GAIN_FRAC     8
`define PPR_POS_MAX       16'h7FFF
`define PPR_NEG_MIN       16'h8000
`define PPR_RESP_OKAY     2'h0
`define PPR_RESP_SLVERR   2'h2

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define PPR_SAMPLE_NS     1000
`define PPR_CLK_MHZ       250

`endif

// [verilog/ppr_sat_mul.v]
`timescale 1ns/1ps
`include "ppr_regs.vh"

module ppr_sat_mul #(
   parameter W = 16
) (
   input  wire signed [W-1:0] a,
   input  wire        [W-1:0] gain,
   output reg  signed [W-1:0] y
);
   wire signed [W:0]     g = {1'b0, gain};
   reg  signed [2*W:0]   prod;
   reg  signed [2*W:0]   sh;
   reg         [W+1:0]   hi;

   // Gain is unsigned with fixed fractional bits; the result saturates.
   always @*
   begin
      prod = a * g;
      sh   = prod >>> `PPR_GAIN_FRAC;
      hi   = sh[2*W:W-1];
      if ((&hi) || (~|hi))
         y = sh[W-1:0];
      else if (sh[2*W])
         y = {1'b1, {(W-1){1'b0}}};
      else
         y = {1'b0, {(W-1){1'b1}}};
   end
endmodule

// [verilog/ppr_ramp.v]
`timescale 1ns/1ps
`include "ppr_regs.vh"

module ppr_ramp #(
   parameter W = 16
) (
   input  wire                aclk,
   input  wire                aresetn,
   input  wire                tick,
   input  wire signed [W-1:0] target,
   input  wire        [W-1:0] step,
   input  wire                bypass,
   output reg  signed [W-1:0] cur_r
);
   wire signed [W:0] diff = {target[W-1], target} - {cur_r[W-1], cur_r};
   wire signed [W:0] stp  = {1'b0, step};

   always @(posedge aclk)
   begin
      if (!aresetn)
         cur_r <= {W{1'b0}};
      else if (bypass || (step == {W{1'b0}}))
         cur_r <= target;
      else if (tick)
      begin
         // The step never overshoots the target, so the ramp settles.
         if (diff > stp)
            cur_r <= cur_r + step;
         else if (diff < -stp)
            cur_r <= cur_r - step;
         else
            cur_r <= target;
      end
   end
endmodule

// [verilog/ppr_regulator.v]
`timescale 1ns/1ps
`include "ppr_regs.vh"

module ppr_regulator #(
   parameter SAMPLE_CYCLES = `PPR_SAMPLE_NS * `PPR_CLK_MHZ / 1000
) (
   input  wire               aclk,
   input  wire               aresetn,
   input  wire [7:0]         s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   input  wire [31:0]        s_axi_wdata,
   input  wire [3:0]         s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   output reg  [1:0]         s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   input  wire [7:0]         s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   output reg  [31:0]        s_axi_rdata,
   output reg  [1:0]         s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready,
   input  wire signed [15:0] first_analog_input,
   input  wire signed [15:0] second_analog_input,
   input  wire signed [15:0] keypad_setpoint,
   input  wire signed [15:0] main_freq_cmd,
   input  wire               ramp_bypass,
   output reg  signed [15:0] freq_ref_r,
   output reg                reverse_cmd_r,
   output reg                selection_error_alarm_r
);
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function signed [15:0] sat18;
      input signed [17:0] v;
      begin
         if (v > $signed({3'b000, 15'h7FFF}))
            sat18 = `PPR_POS_MAX;
         else if (v < $signed({3'b111, 15'h0000}))
            sat18 = `PPR_NEG_MIN;
         else
            sat18 = v[15:0];
      end
   endfunction

   function signed [17:0] ext;
      input signed [15:0] v;
      begin
         ext = {{2{v[15]}}, v};
      end
   endfunction

   function signed [15:0] clamp;
      input signed [15:0] v;
      input        [15:0] lim;
      reg   signed [16:0] l;
      begin
         l = {2'b00, lim[14:0]};
         if ($signed({v[15], v}) > l)
            clamp = l[15:0];
         else if ($signed({v[15], v}) < -l)
            clamp = -l[15:0];
         else
            clamp = v;
      end
   endfunction

   function [15:0] merge;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
         merge[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   function conflict;
      input [2:0] sp;
      input [2:0] fb;
      begin
         conflict = ((sp == `PPR_SRC_AI1) &&
                     ((fb == `PPR_SRC_AI1) || (fb == `PPR_SRC_DIFF))) ||
                    ((sp == `PPR_SRC_AI2) &&
                     ((fb == `PPR_SRC_AI2) || (fb == `PPR_SRC_DIFF)));
      end
   endfunction

   // ------------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------------
   reg        [3:0]  mode_r;
   reg        [2:0]  sp_src_r;
   reg        [2:0]  fb_src_r;
   reg signed [15:0] sp_pct_r;
   reg        [15:0] fb_gain_r;
   reg        [15:0] kp_r;
   reg        [15:0] ti_r;
   reg        [15:0] td_r;
   reg signed [15:0] bias_r;
   reg        [3:0]  filt_r;
   reg        [15:0] ilim_r;
   reg        [15:0] olim_r;
   reg        [15:0] ogain_r;
   reg               rev_allow_r;
   reg        [15:0] ramp_r;
   reg        [7:0]  waddr_r;
   reg        [31:0] wdata_r;
   reg        [3:0]  wstrb_r;
   reg               aw_full_r;
   reg               w_full_r;

   wire        do_write = aw_full_r && w_full_r && !s_axi_bvalid;
   wire [15:0] src_old  = {5'h00, fb_src_r, 5'h00, sp_src_r};
   wire [15:0] src_new  = merge(src_old, wdata_r, wstrb_r);
   wire        src_wr   = do_write && (waddr_r == `PPR_OFS_SRC);
   wire        src_bad  = conflict(src_new[`PPR_SRC_SP_LSB +: 3],
                                   src_new[`PPR_SRC_FB_LSB +: 3]);
   wire        alarm_clr = do_write && (waddr_r == `PPR_OFS_STATUS) &&
                           wstrb_r[0] && wdata_r[`PPR_ST_ALARM];
   wire        known = (waddr_r <= `PPR_OFS_OUT) && (waddr_r[1:0] == 2'b00);

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PPR_RESP_OKAY;
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         waddr_r       <= 8'h00;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
         mode_r        <= `PPR_RST_MODE;
         sp_src_r      <= `PPR_RST_SP_SRC;
         fb_src_r      <= `PPR_RST_FB_SRC;
         sp_pct_r      <= `PPR_RST_ZERO;
         fb_gain_r     <= `PPR_RST_GAIN;
         kp_r          <= `PPR_RST_GAIN;
         ti_r          <= `PPR_RST_ZERO;
         td_r          <= `PPR_RST_ZERO;
         bias_r        <= `PPR_RST_ZERO;
         filt_r        <= `PPR_RST_FILT;
         ilim_r        <= `PPR_RST_LIM;
         olim_r        <= `PPR_RST_LIM;
         ogain_r       <= `PPR_RST_GAIN;
         rev_allow_r   <= 1'b0;
         ramp_r        <= `PPR_RST_ZERO;
         selection_error_alarm_r <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            waddr_r   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write)
         begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
            case (waddr_r)
               `PPR_OFS_MODE:    mode_r    <= wstrb_r[0] ? wdata_r[3:0]
                                                         : mode_r;
               `PPR_OFS_SP_PCT:  sp_pct_r  <= merge(sp_pct_r, wdata_r, wstrb_r);
               `PPR_OFS_FB_GAIN: fb_gain_r <= merge(fb_gain_r, wdata_r, wstrb_r);
               `PPR_OFS_KP:      kp_r      <= merge(kp_r, wdata_r, wstrb_r);
               `PPR_OFS_TI:      ti_r      <= merge(ti_r, wdata_r, wstrb_r);
               `PPR_OFS_TD:      td_r      <= merge(td_r, wdata_r, wstrb_r);
               `PPR_OFS_BIAS:    bias_r    <= merge(bias_r, wdata_r, wstrb_r);
               `PPR_OFS_FILT:    filt_r    <= wstrb_r[0] ? wdata_r[3:0]
                                                         : filt_r;
               `PPR_OFS_ILIM:    ilim_r    <= merge(ilim_r, wdata_r, wstrb_r);
               `PPR_OFS_OLIM:    olim_r    <= merge(olim_r, wdata_r, wstrb_r);
               `PPR_OFS_OGAIN:   ogain_r   <= merge(ogain_r, wdata_r, wstrb_r);
               `PPR_OFS_REV:     rev_allow_r <= wstrb_r[0] ? wdata_r[0]
                                                         : rev_allow_r;
               `PPR_OFS_RAMP:    ramp_r    <= merge(ramp_r, wdata_r, wstrb_r);
               default:          ;
            endcase
            if (src_wr && !src_bad)
            begin
               sp_src_r <= src_new[`PPR_SRC_SP_LSB +: 3];
               fb_src_r <= src_new[`PPR_SRC_FB_LSB +: 3];
            end
         end
         // A conflicting selection in the same write as a clear still sets.
         if (src_wr && src_bad)
            selection_error_alarm_r <= 1'b1;
         else if (alarm_clr)
            selection_error_alarm_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   reg [31:0] rd_mux;
   always @*
   begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `PPR_OFS_MODE:    rd_mux = {28'h0000000, mode_r};
         `PPR_OFS_SRC:     rd_mux = {16'h0000, src_old};
         `PPR_OFS_SP_PCT:  rd_mux = {16'h0000, sp_pct_r};
         `PPR_OFS_FB_GAIN: rd_mux = {16'h0000, fb_gain_r};
         `PPR_OFS_KP:      rd_mux = {16'h0000, kp_r};
         `PPR_OFS_TI:      rd_mux = {16'h0000, ti_r};
         `PPR_OFS_TD:      rd_mux = {16'h0000, td_r};
         `PPR_OFS_BIAS:    rd_mux = {16'h0000, bias_r};
         `PPR_OFS_FILT:    rd_mux = {28'h0000000, filt_r};
         `PPR_OFS_ILIM:    rd_mux = {16'h0000, ilim_r};
         `PPR_OFS_OLIM:    rd_mux = {16'h0000, olim_r};
         `PPR_OFS_OGAIN:   rd_mux = {16'h0000, ogain_r};
         `PPR_OFS_REV:     rd_mux = {31'h00000000, rev_allow_r};
         `PPR_OFS_RAMP:    rd_mux = {16'h0000, ramp_r};
         `PPR_OFS_STATUS:  rd_mux = {29'h00000000, mode_r[`PPR_MODE_EN],
                                     reverse_cmd_r, selection_error_alarm_r};
         `PPR_OFS_OUT:     rd_mux = {16'h0000, freq_ref_r};
         default:          rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PPR_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ((s_axi_araddr <= `PPR_OFS_OUT) &&
                             (s_axi_araddr[1:0] == 2'b00)) ?
                            `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Sample clock and source selection
   // ------------------------------------------------------------------
   reg  [15:0] samp_cnt_r;
   wire        tick = (samp_cnt_r == SAMPLE_CYCLES - 1);
   wire        run  = mode_r[`PPR_MODE_EN];

   always @(posedge aclk)
   begin
      if (!aresetn || tick)
         samp_cnt_r <= 16'h0000;
      else
         samp_cnt_r <= samp_cnt_r + 16'h0001;
   end

   reg signed [15:0] sp_sel;
   reg signed [15:0] fb_raw;
   wire signed [17:0] ai_diff = ext(first_analog_input) -
                                ext(second_analog_input);
   always @*
   begin
      case (sp_src_r)
         `PPR_SRC_KEYPAD: sp_sel = keypad_setpoint;
         `PPR_SRC_AI1:    sp_sel = first_analog_input;
         `PPR_SRC_AI2:    sp_sel = second_analog_input;
         `PPR_SRC_STORED: sp_sel = sp_pct_r;
         default:         sp_sel = 16'h0000;
      endcase
      case (fb_src_r)
         `PPR_SRC_AI1:  fb_raw = first_analog_input;
         `PPR_SRC_AI2:  fb_raw = second_analog_input;
         `PPR_SRC_DIFF: fb_raw = ai_diff[17] ? 16'h0000 : sat18(ai_diff);
         default:       fb_raw = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------------
   // Control terms
   // ------------------------------------------------------------------
   wire signed [15:0] fb;
   wire signed [15:0] sp_ramp;
   wire signed [15:0] p_term;
   wire signed [15:0] d_term;
   wire signed [15:0] out_scaled;
   reg  signed [15:0] integ_r;
   reg  signed [15:0] d_prev_r;
   reg  signed [15:0] lpf_r;
   reg         [15:0] ti_cnt_r;

   ppr_sat_mul #(.W(16)) u_fb_gain (.a(fb_raw), .gain(fb_gain_r),
                                    .y(fb));
   ppr_ramp #(.W(16)) u_ramp (.aclk(aclk), .aresetn(aresetn),
                              .tick(tick), .target(sp_sel),
                              .step(ramp_r), .bypass(ramp_bypass),
                              .cur_r(sp_ramp));

   wire signed [15:0] err    = sat18(ext(sp_ramp) - ext(fb));
   // Derivative on the negated feedback keeps the sign of the error path.
   wire signed [15:0] d_src  = mode_r[`PPR_MODE_DFB] ?
                               sat18(-ext(fb)) : err;
   wire signed [15:0] d_rate = sat18(ext(d_src) - ext(d_prev_r));

   ppr_sat_mul #(.W(16)) u_kp (.a(err), .gain(kp_r), .y(p_term));
   ppr_sat_mul #(.W(16)) u_td (.a(d_rate), .gain(td_r),
                               .y(d_term));

   wire signed [15:0] sum     = sat18(ext(p_term) + ext(integ_r) +
                                      ext(d_term));
   wire signed [15:0] sum_pol = mode_r[`PPR_MODE_POL] ?
                                sat18(-ext(sum)) : sum;
   wire signed [15:0] lim_out = clamp(sum_pol, olim_r);
   wire signed [17:0] lpf_dif = ext(lim_out) - ext(lpf_r);
   wire signed [17:0] lpf_stp = lpf_dif >>> filt_r;
   wire signed [15:0] lpf_nxt = sat18(ext(lpf_r) + lpf_stp);
   wire               neg_out = lpf_r[15];
   wire signed [15:0] mag     = neg_out ? (rev_allow_r ?
                                sat18(-ext(lpf_r)) : 16'h0000)
                                : lpf_r;
   wire signed [15:0] comp    = sat18(ext(mag) + ext(bias_r));

   ppr_sat_mul #(.W(16)) u_ogain (.a(comp), .gain(ogain_r),
                                  .y(out_scaled));

   wire signed [15:0] final_out = mode_r[`PPR_MODE_ADD] ?
                      sat18(ext(out_scaled) + ext(main_freq_cmd)) :
                      out_scaled;

   // ------------------------------------------------------------------
   // Sampled state and outputs
   // ------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         // Disabled: state is cleared to zero and freq_ref_r follows main_freq_cmd.
         integ_r       <= 16'h0000;
         d_prev_r      <= 16'h0000;
         lpf_r         <= 16'h0000;
         ti_cnt_r      <= 16'h0000;
         reverse_cmd_r <= 1'b0;
         freq_ref_r    <= aresetn ? main_freq_cmd : 16'h0000;
      end
      else if (tick)
      begin
         d_prev_r <= d_src;
         lpf_r    <= lpf_nxt;
         if (ti_r == 16'h0000)
         begin
            integ_r  <= 16'h0000;
            ti_cnt_r <= 16'h0000;
         end
         else if (ti_cnt_r >= ti_r - 16'h0001)
         begin
            // One error step per integral time in samples.
            integ_r  <= clamp(sat18(ext(integ_r) + ext(err)),
                              ilim_r);
            ti_cnt_r <= 16'h0000;
         end
         else
            ti_cnt_r <= ti_cnt_r + 16'h0001;
         reverse_cmd_r <= neg_out && rev_allow_r;
         freq_ref_r    <= final_out;
      end
   end
endmodule

// [tb/ppr_regulator_properties.sv]
`timescale 1ns/1ps
module ppr_regulator_properties (
   input wire        aclk,
   input wire        aresetn,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        selection_error_alarm_r
);
// ------------------------------------------------------------
// Bus handshake and alarm checks
// ------------------------------------------------------------
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
sequence s_wr;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_rd;
   s_axi_arvalid && s_axi_arready;
endsequence
chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
   s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
   s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
   else $error("read address taken while busy");
chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=>
   !s_axi_awready) else $error("write address taken while busy");
chk_rd_answer: assert property (s_rd |=> s_axi_rvalid)
   else $error("read answer late");
chk_wr_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
   else $error("write answer late");
chk_rd_unmapped: assert property (s_rd ##0 s_axi_araddr > 8'h3C |=>
   s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read");
chk_wr_unmapped: assert property (s_wr ##0 s_axi_awaddr > 8'h3C |->
   ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("bad write");
chk_alarm_write: assert property (
   $changed(selection_error_alarm_r) |-> $rose(s_axi_bvalid))
   else $error("alarm moved without a register write");
endmodule
bind ppr_regulator ppr_regulator_properties u_props (.*);

// [tb/ppr_drive_model.sv]
`timescale 1ns/1ps
module ppr_drive_model (
   input wire                aclk,
   output logic signed [15:0] first_analog_input,
   output logic signed [15:0] second_analog_input,
   output logic signed [15:0] keypad_setpoint,
   output logic signed [15:0] main_freq_cmd,
   output logic               ramp_bypass
);
// ------------------------------------------------------------
// Converter results, updated at an edge like a sample register
// ------------------------------------------------------------
// The bypass input stays low until a scenario asks for it.
initial
begin
   first_analog_input = 16'h0000;
   second_analog_input = 16'h0000;
   keypad_setpoint = 16'h0000;
   main_freq_cmd = 16'h0000;
   ramp_bypass = 1'b0;
end
task drive(input [15:0] a1, input [15:0] a2, input [15:0] k,
           input [15:0] m);
   @(posedge aclk);
   first_analog_input <= a1;
   second_analog_input <= a2;
   keypad_setpoint <= k;
   main_freq_cmd <= m;
endtask
task bypass(input b);
   @(posedge aclk);
   ramp_bypass <= b;
endtask
endmodule

// [tb/ppr_regulator_tb.sv]
`timescale 1ns/1ps
`include "ppr_regs.vh"
module ppr_regulator_tb;
logic               aclk = 1'b0;
logic               aresetn = 1'b0;
logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
logic               s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
logic               s_axi_rready = 1'b0;
logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata, rv;
logic [3:0]         s_axi_wstrb = 4'hF;
logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
logic               s_axi_arready, s_axi_rvalid, ramp_bypass;
logic signed [15:0] first_analog_input, second_analog_input;
logic signed [15:0] keypad_setpoint, main_freq_cmd, freq_ref_r;
logic               reverse_cmd_r, selection_error_alarm_r;
int                 err_total = 0, tests_run = 0, cyc = 0;
always #2 aclk = ~aclk;
ppr_regulator #(.SAMPLE_CYCLES(4)) DUT (.*);
ppr_drive_model m0 (.*);
task check(input [31:0] seen, input [31:0] exp);
   tests_run++;
   if (seen !== exp)
   begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
   end
endtask
task wr(input [7:0] a, input [31:0] d);
   @(posedge aclk);
   s_axi_awaddr <= a;
   s_axi_wdata <= d;
   s_axi_awvalid <= 1'b1;
   s_axi_wvalid <= 1'b1;
   s_axi_bready <= 1'b1;
   do
   begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
   end
   while (!s_axi_bvalid);
   rs = s_axi_bresp;
   s_axi_bready <= 1'b0;
endtask
task rd(input [7:0] a);
   @(posedge aclk);
   s_axi_araddr <= a;
   s_axi_arvalid <= 1'b1;
   s_axi_rready <= 1'b1;
   do
   begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
   end
   while (!s_axi_rvalid);
   rv = s_axi_rdata;
   rs = s_axi_rresp;
   s_axi_rready <= 1'b0;
endtask
// Six sample ticks: enough for the one-tick filter lag to settle.
task settle;
   repeat (24) @(posedge aclk);
   #1;
endtask
task t_reset;
   rd(`PPR_OFS_SRC);
   check(rv, 32'h0000_0201);
   m0.drive(16'h0200, 16'h0100, 16'h0400, 16'h1234);
   repeat (3) @(posedge aclk);
   #1 check(freq_ref_r, 32'h1234);
   $display("test reset done");
endtask
task t_sources;
   logic [7:0]  sel [4];
   logic [15:0] ex [4];
   sel = '{8'h20, 8'h21, 8'h12, 8'h14};
   ex = '{16'h0300, 16'h0100, 16'h0000, 16'h0600};
   wr(`PPR_OFS_SP_PCT, 32'h0800);
   wr(`PPR_OFS_MODE, 32'h1);
   for (int i = 0; i < 4; i++)
   begin
      wr(`PPR_OFS_SRC, {21'h0, sel[i][6:4], 5'h0, sel[i][2:0]});
      settle;
      check({reverse_cmd_r, freq_ref_r}, {1'b0, ex[i]});
   end
   wr(`PPR_OFS_SRC, 32'h0404);
   settle;
   check(freq_ref_r, 32'h0700);
   m0.drive(16'h0200, 16'h0300, 16'h0400, 16'h1234);
   settle;
   check(freq_ref_r, 32'h0800);
   $display("test sources done");
endtask
task t_gains;
   logic [7:0]  ofs [9];
   logic [15:0] dat [9];
   logic [16:0] ex [9];
   ofs = '{`PPR_OFS_FB_GAIN, `PPR_OFS_KP, `PPR_OFS_OLIM, `PPR_OFS_MODE,
      `PPR_OFS_REV, `PPR_OFS_REV, `PPR_OFS_MODE, `PPR_OFS_BIAS,
      `PPR_OFS_OGAIN};
   dat = '{16'h0200, 16'h0300, 16'h0800, 16'h3, 16'h1, 16'h0, 16'h9,
      16'h0100, 16'h0200};
   ex = '{17'h00400, 17'h00C00, 17'h00800, 17'h0, 17'h10800, 17'h0,
      17'h01A34, 17'h01B34, 17'h02434};
   m0.drive(16'h0200, 16'h0000, 16'h0400, 16'h1234);
   wr(`PPR_OFS_SRC, 32'h0104);
   for (int i = 0; i < 9; i++)
   begin
      wr(ofs[i], {16'h0, dat[i]});
      settle;
      check({reverse_cmd_r, freq_ref_r}, ex[i]);
   end
   $display("test gains done");
endtask
task t_bus;
   wr(`PPR_OFS_SRC, 32'h0101);
   check({rs, selection_error_alarm_r}, 3'b001);
   rd(`PPR_OFS_SRC);
   check(rv, 32'h0104);
   wr(`PPR_OFS_STATUS, 32'h1);
   check(selection_error_alarm_r, 1'b0);
   rd(8'h40);
   check({rs, rv}, {2'h2, 32'h0});
   wr(8'h40, 32'h1);
   check(rs, 2'h2);
   $display("test bus done");
endtask
task t_terms;
   wr(`PPR_OFS_MODE, 32'h1);
   wr(`PPR_OFS_OGAIN, 32'h0100);
   wr(`PPR_OFS_BIAS, 32'h0);
   wr(`PPR_OFS_KP, 32'h0);
   wr(`PPR_OFS_ILIM, 32'h0600);
   wr(`PPR_OFS_TI, 32'h1);
   settle;
   check(freq_ref_r, 32'h0600);
   wr(`PPR_OFS_FILT, 32'h1);
   wr(`PPR_OFS_ILIM, 32'h0200);
   settle;
   check(freq_ref_r > 16'sh0200 && freq_ref_r < 16'sh0400, 1'b1);
   wr(`PPR_OFS_FILT, 32'h0);
   wr(`PPR_OFS_TI, 32'h0);
   wr(`PPR_OFS_KP, 32'h0100);
   wr(`PPR_OFS_RAMP, 32'h0040);
   wr(`PPR_OFS_SP_PCT, 32'h0B00);
   settle;
   check(freq_ref_r > 16'sh0400 && freq_ref_r < 16'sh0700, 1'b1);
   m0.bypass(1'b1);
   settle;
   check(freq_ref_r, 32'h0700);
   $display("test terms done");
endtask
task end_sim;
   $display("tests %0d errors %0d", tests_run, err_total);
   if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
always @(posedge aclk)
begin
   cyc <= cyc + 1;
   if (cyc == 4000)
   begin
      err_total++;
      end_sim;
   end
end
initial
begin
   repeat (4) @(posedge aclk);
   aresetn <= 1'b1;
   t_reset;
   t_sources;
   t_gains;
   t_bus;
   t_terms;
   end_sim;
end
endmodule
